// ---- hw/tciu_cfg.svh ----
// Register offsets, field positions, reset values and timing counts for the interrupt unit.
`ifndef TCIU_CFG_SVH
`define TCIU_CFG_SVH
`define TCIU_CLK_MHZ        250
`define TCIU_US_NS          1000
`define TCIU_US_CYC         ((`TCIU_US_NS * `TCIU_CLK_MHZ) / 1000)
`define TCIU_TICK_US        1024
`define TCIU_SLEEP_US_DEF   1024
`define TCIU_NSRC           22
`define TCIU_OFS_PEND       12'h000
`define TCIU_OFS_MASK       12'h004
`define TCIU_OFS_VEC        12'h008
`define TCIU_OFS_ACK        12'h00c
`define TCIU_OFS_FRT        12'h010
`define TCIU_OFS_PIT        12'h014
`define TCIU_OFS_CAP        12'h018
`define TCIU_OFS_CAPCFG     12'h01c
`define TCIU_OFS_GPEN       12'h020
`define TCIU_OFS_GPPOL      12'h024
`define TCIU_OFS_SYSCFG     12'h028
`define TCIU_OFS_P23CFG     12'h02c
`define TCIU_MASK_RST       32'h0000_0000
`define TCIU_SYS_PITEN      0
`define TCIU_SYS_SLPEN      1
`define TCIU_SYS_LVDINT     2
`define TCIU_CAP_GANG       3
`define TCIU_CAP_SEL_LSB    0
`define TCIU_P23_EN2        0
`define TCIU_P23_POL2       1
`define TCIU_P23_EN3        2
`define TCIU_P23_POL3       3
`define TCIU_V_BUSRST       0
`define TCIU_V_SUPPLY       1
`define TCIU_V_PIT          2
`define TCIU_V_TICK         3
`define TCIU_V_EP0          4
`define TCIU_V_CAPA         7
`define TCIU_V_CAPB         8
`define TCIU_V_GP0          9
`define TCIU_V_DPA          13
`define TCIU_V_SER0         16
`define TCIU_V_WRAP         18
`define TCIU_V_SLEEP        19
`define TCIU_V_ACTIVE       20
`define TCIU_V_SPARE        21
`endif

// ---- hw/tciu_pkg.sv ----
// Types shared by the timer, capture and interrupt unit.
package tciu_pkg;
    typedef logic [4:0] tciu_vec_t;
    typedef struct packed {
        logic       valid;
        tciu_vec_t  vector;
    } tciu_req_s;
    typedef struct packed {
        logic [7:0] port0;
        logic [7:0] port1;
        logic [1:0] port2;
        logic [1:0] port3;
    } tciu_pins_s;
    typedef struct packed {
        logic       busReset;
        logic [2:0] epDone;
        logic [1:0] serial;
        logic       busActive;
        logic       supplyDrop;
    } tciu_evt_s;
endpackage

// ---- hw/tciu_top.sv ----
// Vectored interrupt unit with free-running, interval, sleep and capture timers.
`timescale 1ns/1ps
`include "tciu_cfg.svh"
`default_nettype none
// Register map, byte addresses:
//   0x00 pending flags; write ones to clear.
//   0x04 mask; a one enables the source.
//   0x08 lowest active vector; 31 when none.
//   0x0c spare slot; reads zero.
//   0x10 free-running count, read only.
//   0x14 interval reload; reads the live count.
//   0x18 captures, B in 15:8 and A in 7:0.
//   0x1c slice select in 2:0, gang in bit 3.
//   0x20 GPIO enables, port one in 15:8.
//   0x24 GPIO polarity; one means falling.
//   0x28 interval, sleep and supply-irq enables.
//   0x2c ports two and three, enable and polarity.
//   Other addresses read zero, ignore writes.
//
// Vectors, the lowest active one wins:
//   0 bus reset, 1 supply drop.
//   2 interval timer, 3 millisecond tick.
//   4 to 6 endpoints, 7 and 8 captures.
//   9 to 12 GPIO ports zero to three.
//   13 to 15 dedicated port-zero pins.
//   16 and 17 serial, 18 wrap, 19 sleep.
//   20 bus activity; 21 is never raised.
//
// Latency:
//   A pin edge passes two sync flops and an
//   edge flop; its flag sets on the third edge.
//   Request and irq follow one cycle later.
//   An acknowledge clears its flag at once, and
//   the next request already leaves it out.
//   Setup is registered, so pready stands in
//   the first access cycle; no wait states.
//   Read data reflect the state at setup.
//
// Limitations:
//   Capture fires on rising pin edges only.
//   In ganged mode pin B raises nothing.
//   Dedicated pins are always armed for rising
//   edges and may also count as port-zero GPIO.
//   The supply reset output follows the drop
//   level while the supply irq enable is clear
//   and stays low while it is set; nothing about it is latched.
//   Sleep and tick periods are fixed.
//   Ports two and three share one enable and
//   one polarity per port.
//
// Hazards:
//   Set beats clear, so an event that meets its
//   acknowledge or clear in one cycle survives.
//   The request uses the flags left after this
//   cycle's clears, so no vector is seen twice.
//   The interval timer reloads on its expiry
//   step, so the period never drifts.
//   Only the second flop reads the first one
//   of each synchroniser.
//   A new slice select affects only later
//   captures; latched values stay.
//
// Clocking:
//   One clock drives all logic; a shared
//   prescaler makes the microsecond step.
//   All outputs are low in reset and the
//   first setup may follow the release edge.
module tciu_top (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rstn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pins and peripheral events.
    input  wire tciu_pkg::tciu_pins_s pins,
    input  wire tciu_pkg::tciu_evt_s  events,
    // Core interface.
    input  wire logic              vecAck,
    output tciu_pkg::tciu_req_s    coreReq,
    output logic                   irq,
    output logic                   supplyDropReset,
    output logic [15:0]            fetchAddr
);
    import tciu_pkg::*;

    localparam int unsigned US_CYC = `TCIU_US_CYC;
    localparam int unsigned NS     = `TCIU_NSRC;

    // Lowest-numbered set bit, shared by vector output and read-back.
    function automatic tciu_vec_t lowestSet(input logic [NS-1:0] v);
        lowestSet = 5'h1f;
        for (int i = NS - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowestSet = tciu_vec_t'(i);
            end
        end
    endfunction

    // Two-flop synchronisers for every pin and asynchronous event.
    tciu_pins_s pinS1_r, pinS2_r, pinOld_r;
    tciu_evt_s  evtS1_r, evtS2_r, evtOld_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinS1_r  <= '0;
            pinS2_r  <= '0;
            pinOld_r <= '0;
            evtS1_r  <= '0;
            evtS2_r  <= '0;
            evtOld_r <= '0;
        end else begin
            pinS1_r  <= pins;
            pinS2_r  <= pinS1_r;
            pinOld_r <= pinS2_r;
            evtS1_r  <= events;
            evtS2_r  <= evtS1_r;
            evtOld_r <= evtS2_r;
        end
    end

    // Software-visible configuration.
    logic [NS-1:0] mask_r;
    logic [15:0]   gpEn_r, gpPol_r;
    logic [3:0]    p23Cfg_r, capCfg_r;
    logic [2:0]    sysCfg_r;
    logic [11:0]   pitReload_r;
    logic          apbWr, apbAcc;
    assign apbAcc = psel && penable;
    assign apbWr  = apbAcc && pwrite;

    // Configuration writes; mask bit set means the source is enabled.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_r      <= NS'(`TCIU_MASK_RST);
            gpEn_r      <= '0;
            gpPol_r     <= '0;
            p23Cfg_r    <= '0;
            capCfg_r    <= '0;
            sysCfg_r    <= '0;
            pitReload_r <= '0;
        end else if (apbWr) begin
            unique case (paddr)
                `TCIU_OFS_MASK:   mask_r      <= pwdata[NS-1:0];
                `TCIU_OFS_GPEN:   gpEn_r      <= pwdata[15:0];
                `TCIU_OFS_GPPOL:  gpPol_r     <= pwdata[15:0];
                `TCIU_OFS_P23CFG: p23Cfg_r    <= pwdata[3:0];
                `TCIU_OFS_CAPCFG: capCfg_r    <= pwdata[3:0];
                `TCIU_OFS_SYSCFG: sysCfg_r    <= pwdata[2:0];
                `TCIU_OFS_PIT:    pitReload_r <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // Microsecond prescaler shared by all timers.
    logic [7:0] usDiv_r;
    logic       usStep;
    assign usStep = (usDiv_r == 8'(US_CYC - 1));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            usDiv_r <= '0;
        end else begin
            usDiv_r <= usStep ? 8'h00 : usDiv_r + 8'h01;
        end
    end

    // Free-running 16-bit microsecond counter; tick when low ten bits roll.
    logic [15:0] frt_r;
    logic        tickEvt, wrapEvt;
    assign tickEvt = usStep && (frt_r[9:0] == 10'(`TCIU_TICK_US - 1));
    assign wrapEvt = usStep && (frt_r == 16'hffff);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frt_r <= '0;
        end else if (usStep) begin
            frt_r <= frt_r + 16'h0001;
        end
    end

    // Interval timer reloads on expiry so periods stay exact.
    logic [11:0] pit_r;
    logic        pitEvt;
    assign pitEvt = sysCfg_r[`TCIU_SYS_PITEN] && usStep && (pit_r == 12'h000);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pit_r <= '0;
        end else if (!sysCfg_r[`TCIU_SYS_PITEN]) begin
            pit_r <= pitReload_r;
        end else if (usStep) begin
            pit_r <= (pit_r == 12'h000) ? pitReload_r : pit_r - 12'h001;
        end
    end

    // Sleep timer repeats at a fixed interval while enabled.
    logic [10:0] slp_r;
    logic        slpEvt;
    assign slpEvt = sysCfg_r[`TCIU_SYS_SLPEN] && usStep
                    && (slp_r == 11'(`TCIU_SLEEP_US_DEF - 1));
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            slp_r <= '0;
        end else if (!sysCfg_r[`TCIU_SYS_SLPEN] || slpEvt) begin
            slp_r <= '0;
        end else if (usStep) begin
            slp_r <= slp_r + 11'h001;
        end
    end

    // Capture on rising edge of each capture pin; ganged mode latches all 16 bits on pin A.
    logic [7:0]  capA_r, capB_r;
    logic [1:0]  capEvt;
    logic [7:0]  capSlice;
    logic        gang;
    assign gang     = capCfg_r[`TCIU_CAP_GANG];
    assign capSlice = 8'(frt_r >> {capCfg_r[2:0], 1'b0});
    assign capEvt[0] = pinS2_r.port0[5] && !pinOld_r.port0[5];
    assign capEvt[1] = pinS2_r.port0[6] && !pinOld_r.port0[6] && !gang;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            capA_r <= '0;
            capB_r <= '0;
        end else begin
            if (capEvt[0]) begin
                capA_r <= gang ? frt_r[7:0] : capSlice;
            end
            if (capEvt[0] && gang) begin
                capB_r <= frt_r[15:8];
            end else if (capEvt[1]) begin
                capB_r <= capSlice;
            end
        end
    end

    // GPIO edges; ports 0 and 1 per pin, ports 2 and 3 whole port.
    logic [3:0] gpEvt;
    logic [2:0] dedEvt;
    function automatic logic edgeHit(input logic now, input logic old, input logic pol);
        edgeHit = pol ? (!now && old) : (now && !old);
    endfunction
    always_comb begin
        gpEvt = '0;
        for (int i = 0; i < 8; i++) begin
            gpEvt[0] |= gpEn_r[i] && edgeHit(pinS2_r.port0[i], pinOld_r.port0[i], gpPol_r[i]);
            gpEvt[1] |= gpEn_r[8+i]
                        && edgeHit(pinS2_r.port1[i], pinOld_r.port1[i], gpPol_r[8+i]);
        end
        for (int i = 0; i < 2; i++) begin
            gpEvt[2] |= p23Cfg_r[`TCIU_P23_EN2]
                        && edgeHit(pinS2_r.port2[i], pinOld_r.port2[i], p23Cfg_r[`TCIU_P23_POL2]);
            gpEvt[3] |= p23Cfg_r[`TCIU_P23_EN3]
                        && edgeHit(pinS2_r.port3[i], pinOld_r.port3[i], p23Cfg_r[`TCIU_P23_POL3]);
        end
    end
    // Dedicated pins are rising-edge and independent of GPIO enables.
    assign dedEvt = pinS2_r.port0[4:2] & ~pinOld_r.port0[4:2];

    // Event vector in source order.
    logic [NS-1:0] srcEvt;
    logic [2:0]    epRise;
    logic          supplyEvt;
    assign epRise    = evtS2_r.epDone & ~evtOld_r.epDone;
    assign supplyEvt = evtS2_r.supplyDrop && !evtOld_r.supplyDrop
                       && sysCfg_r[`TCIU_SYS_LVDINT];
    always_comb begin
        srcEvt = '0;
        srcEvt[`TCIU_V_BUSRST]           = evtS2_r.busReset && !evtOld_r.busReset;
        srcEvt[`TCIU_V_SUPPLY]           = supplyEvt;
        srcEvt[`TCIU_V_PIT]              = pitEvt;
        srcEvt[`TCIU_V_TICK]             = tickEvt;
        srcEvt[`TCIU_V_EP0 +: 3]         = epRise;
        srcEvt[`TCIU_V_CAPA]             = capEvt[0];
        srcEvt[`TCIU_V_CAPB]             = capEvt[1];
        srcEvt[`TCIU_V_GP0 +: 4]         = gpEvt;
        srcEvt[`TCIU_V_DPA +: 3]         = dedEvt;
        srcEvt[`TCIU_V_SER0 +: 2]        = evtS2_r.serial & ~evtOld_r.serial;
        srcEvt[`TCIU_V_WRAP]             = wrapEvt;
        srcEvt[`TCIU_V_SLEEP]            = slpEvt;
        srcEvt[`TCIU_V_ACTIVE]           = evtS2_r.busActive && !evtOld_r.busActive;
        srcEvt[`TCIU_V_SPARE]            = 1'b0;
    end

    // Pending flags: event set beats acknowledge or write-one clear.
    logic [NS-1:0] pend_r, active;
    tciu_vec_t     vecSel;
    logic [NS-1:0] clrMask;
    assign active = pend_r & mask_r;
    assign vecSel = lowestSet(active);
    always_comb begin
        clrMask = '0;
        if (apbWr && paddr == `TCIU_OFS_PEND) begin
            clrMask = pwdata[NS-1:0];
        end
        if (vecAck && coreReq.valid) begin
            clrMask[coreReq.vector] = 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~clrMask) | srcEvt;
        end
    end

    // Core request, interrupt level and reset outputs from flops.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            coreReq         <= '0;
            irq             <= 1'b0;
            supplyDropReset <= 1'b0;
            fetchAddr       <= 16'h0000;
        end else begin
            coreReq.valid   <= |(active & ~clrMask);
            coreReq.vector  <= lowestSet(active & ~clrMask);
            irq             <= |(active & ~clrMask);
            supplyDropReset <= evtS2_r.supplyDrop && !sysCfg_r[`TCIU_SYS_LVDINT];
            fetchAddr       <= 16'h0000;
        end
    end

    // APB read data and response; zero wait states, unmapped reads zero.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `TCIU_OFS_PEND:   prdata <= 32'(pend_r);
                    `TCIU_OFS_MASK:   prdata <= 32'(mask_r);
                    `TCIU_OFS_VEC:    prdata <= 32'(vecSel);
                    `TCIU_OFS_FRT:    prdata <= 32'(frt_r);
                    `TCIU_OFS_PIT:    prdata <= {20'h00000, pit_r};
                    `TCIU_OFS_CAP:    prdata <= {16'h0000, capB_r, capA_r};
                    `TCIU_OFS_CAPCFG: prdata <= 32'(capCfg_r);
                    `TCIU_OFS_GPEN:   prdata <= 32'(gpEn_r);
                    `TCIU_OFS_GPPOL:  prdata <= 32'(gpPol_r);
                    `TCIU_OFS_SYSCFG: prdata <= 32'(sysCfg_r);
                    `TCIU_OFS_P23CFG: prdata <= 32'(p23Cfg_r);
                    default:          prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    // Unused spare bits of the event struct would warn otherwise; none here.
endmodule // tciu_top
`default_nettype wire

// ---- verification/tciu_top_asserts.sv ----
// Concurrent checks on the ports of the interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module tciu_top_asserts (
    // Clock and reset.
    input wire logic                clock,
    input wire logic                rstn,
    // APB slave side.
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Events and core side.
    input wire tciu_pkg::tciu_evt_s events,
    input wire logic                vecAck,
    input wire tciu_pkg::tciu_req_s coreReq,
    input wire logic                irq,
    input wire logic                supplyDropReset,
    input wire logic [15:0]         fetchAddr
);
    import tciu_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // Setup and completed access phases of one APB transfer.
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbDone;
        psel && penable && pready;
    endsequence
    // The slave answers without wait states, so a held request completes next cycle.
    AST_SETUP_ANSWER: assert property (apbSetup |=> apbDone)
        else $error("setup phase not answered in the next cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready stood for more than one cycle");
    AST_NO_ERROR: assert property (pslverr == 1'b0)
        else $error("pslverr raised");
    AST_UNMAPPED_ZERO: assert property (psel && penable && pready && !pwrite
        && paddr >= 12'h030 |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    AST_FETCH_ZERO: assert property (fetchAddr == 16'h0000)
        else $error("fetch address is not zero");
    AST_RESET_QUIET: assert property ($rose(rstn) |-> !irq && !coreReq.valid)
        else $error("request active right after reset");
    AST_VECTOR_RANGE: assert property (coreReq.valid |-> coreReq.vector <= 5'h14)
        else $error("request carries a vector outside the sources");
    // The request view drops the acknowledged vector one cycle on already; the check waits one cycle more.
    AST_ACK_CLEARS: assert property (coreReq.valid && vecAck |=> ##1
        !(coreReq.valid && coreReq.vector == $past(coreReq.vector, 2)))
        else $error("acknowledged vector still requested");
    AST_DROP_RESET: assert property ($rose(supplyDropReset) |-> events.supplyDrop)
        else $error("supply reset without a supply drop");
endmodule // tciu_top_asserts
bind tciu_top tciu_top_asserts u_chk (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .vecAck(vecAck), .coreReq(coreReq), .irq(irq),
    .supplyDropReset(supplyDropReset), .fetchAddr(fetchAddr)
);
`default_nettype wire

// ---- verification/tciu_core_model.sv ----
// Behavioural processor core that takes vectored requests and acknowledges them.
`timescale 1ns/1ps
`default_nettype none
module tciu_core_model (
    // Clock and reset.
    input wire logic                clock,
    input wire logic                rstn,
    // Request and acknowledge.
    input wire tciu_pkg::tciu_req_s coreReq,
    output logic                    vecAck,
    // Bench control and observation.
    input wire logic                ackOn,
    input wire logic [3:0]          ackWait,
    output logic [4:0]              lastVec,
    output logic [7:0]              ackCount
);
    import tciu_pkg::*;
    logic [4:0] gap_r;
    // Spacing of at least two cycles lets the request settle before the next look.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vecAck <= 1'b0;
            gap_r <= 5'h00;
            lastVec <= 5'h1f;
            ackCount <= 8'h00;
        end else if (!vecAck && coreReq.valid && ackOn && gap_r >= {1'b0, ackWait} + 5'h02) begin
            vecAck <= 1'b1;
            ackCount <= ackCount + 8'h01;
            gap_r <= 5'h00;
        end else begin
            // Record the vector that stands at the edge where the acknowledge is taken.
            if (vecAck) begin
                lastVec <= coreReq.vector;
            end
            vecAck <= 1'b0;
            gap_r <= (gap_r == 5'h1f) ? gap_r : gap_r + 5'h01;
        end
    end
endmodule // tciu_core_model
`default_nettype wire

// ---- verification/timer_capture_interrupt_unit_tb.sv ----
// Self-checking bench for the timer, capture and interrupt unit.
`timescale 1ns/1ps
`include "tciu_cfg.svh"
`default_nettype none
module timer_capture_interrupt_unit_tb;
    import tciu_pkg::*;
    logic clock, rstn, psel, penable, pwrite, vecAck, irq, pready, pslverr;
    logic supplyDropReset, ackOn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] fetchAddr;
    logic [4:0] lastVec;
    logic [7:0] ackCount;
    logic [3:0] ackWait;
    tciu_pins_s pins;
    tciu_evt_s events;
    tciu_req_s coreReq;
    int miscompares, totalChecks, cyc;
    tciu_top DUT (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .events(events),
        .vecAck(vecAck), .coreReq(coreReq), .irq(irq),
        .supplyDropReset(supplyDropReset), .fetchAddr(fetchAddr));
    tciu_core_model u_core (.clock(clock), .rstn(rstn), .coreReq(coreReq),
        .vecAck(vecAck), .ackOn(ackOn), .ackWait(ackWait), .lastVec(lastVec),
        .ackCount(ackCount));
    // Free-running clock and cycle count.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; a silent slave is caught by the watchdog.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic testReset();
        check("fetch", fetchAddr, 32'h0);
        check("req", coreReq.valid, 32'h0);
        rdChk("mask", `TCIU_OFS_MASK, `TCIU_MASK_RST);
        wr(12'h0fc, 32'hffff_ffff);
        rdChk("unmapped", 12'h0fc, 32'h0);
    endtask
    task automatic testPriority();
        @(posedge clock);
        events.busReset <= 1'b1;
        events.epDone[1] <= 1'b1;
        idle(6);
        rdChk("pend", `TCIU_OFS_PEND, 32'h1 | (32'h1 << (`TCIU_V_EP0 + 1)));
        check("irq masked", irq, 32'h0);
        wr(`TCIU_OFS_MASK, 32'h003f_ffff);
        idle(3);
        check("vector", coreReq.vector, `TCIU_V_BUSRST);
        check("irq", irq, 32'h1);
        rdChk("vec reg", `TCIU_OFS_VEC, `TCIU_V_BUSRST);
        ackOn <= 1'b1;
        idle(30);
        check("last ack", lastVec, `TCIU_V_EP0 + 1);
        check("acks", ackCount, 32'h2);
        check("irq done", irq, 32'h0);
        ackOn <= 1'b0;
        events.busReset <= 1'b0;
        events.epDone <= 3'h0;
    endtask
    task automatic testSupply();
        @(posedge clock);
        events.supplyDrop <= 1'b1;
        idle(6);
        check("drop reset", supplyDropReset, 32'h1);
        events.supplyDrop <= 1'b0;
        wr(`TCIU_OFS_SYSCFG, 32'h1 << `TCIU_SYS_LVDINT);
        wr(`TCIU_OFS_PEND, 32'h003f_ffff);
        events.supplyDrop <= 1'b1;
        idle(6);
        check("drop irq", supplyDropReset, 32'h0);
        rdChk("drop pend", `TCIU_OFS_PEND, 32'h1 << `TCIU_V_SUPPLY);
        events.supplyDrop <= 1'b0;
        wr(`TCIU_OFS_PEND, 32'h003f_ffff);
        events.serial <= 2'b10;
        events.busActive <= 1'b1;
        idle(6);
        rdChk("serial", `TCIU_OFS_PEND,
              (32'h2 << `TCIU_V_SER0) | (32'h1 << `TCIU_V_ACTIVE));
        events.serial <= 2'b00;
        events.busActive <= 1'b0;
        wr(`TCIU_OFS_PEND, 32'h003f_ffff);
    endtask
    task automatic testGpio();
        wr(`TCIU_OFS_GPEN, 32'h1);
        wr(`TCIU_OFS_GPPOL, 32'h1);
        wr(`TCIU_OFS_P23CFG, 32'h1 << `TCIU_P23_EN2);
        pins.port0[0] <= 1'b1;
        idle(6);
        rdChk("rise off", `TCIU_OFS_PEND, 32'h0);
        pins.port0[0] <= 1'b0;
        idle(6);
        rdChk("fall", `TCIU_OFS_PEND, 32'h1 << `TCIU_V_GP0);
        wr(`TCIU_OFS_PEND, 32'h003f_ffff);
        pins.port0[2] <= 1'b1;
        pins.port2[1] <= 1'b1;
        idle(6);
        rdChk("pins", `TCIU_OFS_PEND, (32'h1 << `TCIU_V_DPA) | (32'h1 << (`TCIU_V_GP0 + 2)));
    endtask
    // Separate channels first, then ganged, where pin B no longer counts.
    task automatic testCapture();
        logic [31:0] f0, f1, c;
        wr(`TCIU_OFS_PEND, 32'h003f_ffff);
        pins.port0[6:5] <= 2'b11;
        idle(6);
        rdChk("capture", `TCIU_OFS_PEND, 32'h3 << `TCIU_V_CAPA);
        pins.port0[6:5] <= 2'b00;
        idle(6);
        wr(`TCIU_OFS_PEND, 32'h003f_ffff);
        wr(`TCIU_OFS_CAPCFG, 32'h1 << `TCIU_CAP_GANG);
        idle(500);
        xfer(1'b0, `TCIU_OFS_FRT, 32'h0, f0);
        pins.port0[6:5] <= 2'b11;
        idle(6);
        rdChk("gang", `TCIU_OFS_PEND, 32'h1 << `TCIU_V_CAPA);
        xfer(1'b0, `TCIU_OFS_CAP, 32'h0, c);
        xfer(1'b0, `TCIU_OFS_FRT, 32'h0, f1);
        check("gang value", c >= f0 && c <= f1, 32'h1);
    endtask
    task automatic waitPit(output int at);
        logic [31:0] q;
        do begin
            xfer(1'b0, `TCIU_OFS_PEND, 32'h0, q);
        end while (q[`TCIU_V_PIT] !== 1'b1);
        at = cyc;
        wr(`TCIU_OFS_PEND, 32'h1 << `TCIU_V_PIT);
    endtask
    // Reload 2 gives three microseconds, 750 cycles; polling blurs it by a few cycles.
    task automatic testPit();
        int t1, t2;
        wr(`TCIU_OFS_PIT, 32'h2);
        wr(`TCIU_OFS_SYSCFG, 32'h1 << `TCIU_SYS_PITEN);
        waitPit(t1);
        waitPit(t2);
        check("pit period", (t2 - t1 >= 740) && (t2 - t1 <= 760), 32'h1);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence after a two-cycle reset.
    initial begin
        {rstn, psel, penable, pwrite, ackOn} = 5'h0;
        {paddr, pwdata, pins, events} = '0;
        {miscompares, totalChecks, cyc} = '0;
        ackWait = 4'h3;
        idle(2);
        rstn <= 1'b1;
        testReset();
        testPriority();
        testSupply();
        testGpio();
        testCapture();
        testPit();
        complete_run();
    end
    // Watchdog sized well past the expected run.
    initial begin
        idle(20000);
        miscompares++;
        complete_run();
    end
endmodule // timer_capture_interrupt_unit_tb
`default_nettype wire
